//--- include/mft_pkg.sv
// Package for the multifunction timer: offsets, fields, resets, types.
// Assumes a byte-addressed word register port, 8 address bits.
package mft_pkg;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int CNT_W    = 16;
	localparam int PRE_W    = 8;
	localparam int IO_COUNT = 26;
	localparam int ROUTE_W  = 8;
	localparam int IRQ_W    = 4;

	// Register offsets
	localparam logic [7:0] OFF_MODE_CONTROL = 8'h00;
	localparam logic [7:0] OFF_CLOCK_SELECT = 8'h04;
	localparam logic [7:0] OFF_PRESCALER    = 8'h08;
	localparam logic [7:0] OFF_COUNTER_ONE  = 8'h0C;
	localparam logic [7:0] OFF_COUNTER_TWO  = 8'h10;
	localparam logic [7:0] OFF_RELOAD_A     = 8'h14;
	localparam logic [7:0] OFF_RELOAD_B     = 8'h18;
	localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h1C;
	localparam logic [7:0] OFF_IRQ_PENDING  = 8'h20;
	localparam logic [7:0] OFF_ROUTING      = 8'h44;

	// Reset values
	localparam logic [31:0] MODE_CONTROL_RST = 32'h00000000;
	localparam logic [31:0] CLOCK_SELECT_RST = 32'h00000000;
	localparam logic [7:0]  PRESCALER_RST    = 8'h00;
	localparam logic [15:0] COUNTER_RST      = 16'h0000;
	localparam logic [15:0] RELOAD_RST       = 16'h0000;
	localparam logic [3:0]  IRQ_RST          = 4'h0;
	localparam logic [31:0] ROUTING_RST      = 32'h00000000;

	// Counter presets
	localparam logic [15:0] CNT_PRESET = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;

	// Routing field positions
	localparam int ROUTE_T1A_LSB = 0;
	localparam int ROUTE_T1B_LSB = 8;
	localparam int ROUTE_T2A_LSB = 16;
	localparam int ROUTE_T2B_LSB = 24;

	// Pending and enable bit positions
	localparam int IRQ_A = 0;
	localparam int IRQ_B = 1;
	localparam int IRQ_C = 2;
	localparam int IRQ_D = 3;

	typedef enum logic [1:0] {
		MODE_PWM            = 2'h0,
		MODE_DUAL_CAPTURE   = 2'h1,
		MODE_DUAL_TIMER     = 2'h2,
		MODE_SINGLE_CAPTURE = 2'h3
	} mode_e;

	typedef enum logic [2:0] {
		CLK_NONE       = 3'h0,
		CLK_PRESCALED  = 3'h1,
		CLK_EVENT      = 3'h2,
		CLK_ACCUMULATE = 3'h3
	} clk_src_e;

	typedef enum logic [1:0] {
		NEXT_RELOAD_A = 2'b01,
		NEXT_RELOAD_B = 2'b10
	} reload_order_e;

	typedef struct packed {
		logic [22:0] reserved;
		logic        pin_b_preset;
		logic        pin_a_preset;
		logic        pin_b_rising;
		logic        pin_a_rising;
		logic        pulse_train;
		logic        initial_output_level;
		logic        enable;
		mode_e       mode_select_field;
	} mode_control_s;

	typedef struct packed {
		logic [24:0] reserved;
		clk_src_e    two;
		logic        gap;
		clk_src_e    one;
	} clock_select_s;
endpackage

//--- src/edge_detect.sv
// Programmable edge detector for one timer pin.
// Assumes the pin is already synchronous to the clock.
module edge_detect (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// Pin and polarity
	input  wire logic pin_i,
	input  wire logic rising_i,
	// Event
	output logic      edge_o
);
	logic prev;
	logic next_prev;

	// Previous level tracks the pin
	always_comb begin
		next_prev = pin_i;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			prev <= 1'b0;
		end else begin
			prev <= next_prev;
		end
	end

	// Chosen edge only, so a glitch of either polarity still gives one event at its chosen edge
	assign edge_o = rising_i ? (pin_i & ~prev) : (~pin_i & prev);
endmodule

//--- src/prescaler.sv
// Eight-bit prescaler: one enable pulse every divisor+1 system clocks.
// Assumes the divisor may change at any time; a new value takes effect at once, against the running count.
module prescaler (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	// Control
	input  wire logic             run_i,
	input  wire logic [7:0]       div_i,
	// Enable pulse
	output logic                  tick_o
);
	logic [7:0] count;
	logic [7:0] next_count;
	logic       next_tick;

	// Count up to the divisor, then pulse and wrap
	always_comb begin
		next_count = count;
		next_tick  = 1'b0;
		if (!run_i) begin
			next_count = 8'h00;
		end else if (count >= div_i) begin
			next_count = 8'h00;
			next_tick  = 1'b1;
		end else begin
			next_count = count + 8'h01;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			count  <= 8'h00;
			tick_o <= 1'b0;
		end else begin
			count  <= next_count;
			tick_o <= next_tick;
		end
	end
endmodule

//--- src/multifunction_timer.sv
// Multifunction timer: two down-counters, two reload/capture registers, PWM.
// Assumes a single-cycle register port and pins synchronous to mclk_i.
module multifunction_timer #(
	parameter logic TIMER_UNIT = 1'b0
) (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// Register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Timer pins and routed IO
	input  wire logic        pin_a_i,
	input  wire logic        pin_b_i,
	input  wire logic [25:0] io_i,
	output logic             pwm_output_pin_o,
	output logic             pin_a_oe_o,
	// Interrupts
	output logic             irq_one_o,
	output logic             irq_two_o
);
	mft_pkg::mode_control_s timer_mode_control;
	mft_pkg::mode_control_s next_mode_control;
	mft_pkg::clock_select_s counter_clock_select;
	mft_pkg::clock_select_s next_clock_select;
	mft_pkg::reload_order_e reload_order;
	mft_pkg::reload_order_e next_reload_order;
	logic [7:0]  prescale_div;
	logic [7:0]  next_prescale_div;
	logic [15:0] counter_one;
	logic [15:0] next_counter_one;
	logic [15:0] counter_two;
	logic [15:0] next_counter_two;
	logic [15:0] reload_capture_a;
	logic [15:0] next_reload_capture_a;
	logic [15:0] reload_capture_b;
	logic [15:0] next_reload_capture_b;
	logic [3:0]  irq_enable;
	logic [3:0]  next_irq_enable;
	logic [3:0]  irq_pending;
	logic [3:0]  next_irq_pending;
	logic [31:0] timer_input_routing;
	logic [31:0] next_routing;
	logic        train_stopped;
	logic        next_train_stopped;
	logic        next_pin;
	logic        next_oe;
	logic        next_irq_one;
	logic        next_irq_two;
	logic [31:0] next_rdata;

	// Bus decode
	logic        wr_ctrl;
	logic        wr_clk;
	logic        wr_pre;
	logic        wr_cnt1;
	logic        wr_cnt2;
	logic        wr_cra;
	logic        wr_crb;
	logic        wr_ien;
	logic        wr_pend;
	logic        wr_route;

	// Pin sourcing and events
	logic [7:0]  route_a_code;
	logic [7:0]  route_b_code;
	logic        routed;
	logic        pin_a_src;
	logic        pin_b_src;
	logic        edge_a;
	logic        edge_b;
	logic        pre_tick;

	// Counter timing
	mft_pkg::mode_e mode;
	logic        is_train;
	logic        run_one;
	logic        tick_one;
	logic        tick_two;
	logic        under_one;
	logic        under_two;
	logic [3:0]  set_pend;

	// Pick one IO by routing code; codes past the last IO read low
	function automatic logic route_pick(input logic [7:0] code, input logic [25:0] io);
		logic hit;
		hit = 1'b0;
		if (code < 8'h1A) begin
			hit = io[code[4:0]];
		end
		return hit;
	endfunction

	// Counting pulse for one clock source choice
	function automatic logic source_tick(input mft_pkg::clk_src_e src, input logic pre,
			input logic b_edge, input logic b_level);
		logic t;
		t = 1'b0;
		case (src)
			mft_pkg::CLK_PRESCALED:  t = pre;
			mft_pkg::CLK_EVENT:      t = b_edge;
			mft_pkg::CLK_ACCUMULATE: t = pre & b_level;
			default:                 t = 1'b0;
		endcase
		return t;
	endfunction

	// Write strobes per register
	always_comb begin
		wr_ctrl  = wr_i && (addr_i == mft_pkg::OFF_MODE_CONTROL);
		wr_clk   = wr_i && (addr_i == mft_pkg::OFF_CLOCK_SELECT);
		wr_pre   = wr_i && (addr_i == mft_pkg::OFF_PRESCALER);
		wr_cnt1  = wr_i && (addr_i == mft_pkg::OFF_COUNTER_ONE);
		wr_cnt2  = wr_i && (addr_i == mft_pkg::OFF_COUNTER_TWO);
		wr_cra   = wr_i && (addr_i == mft_pkg::OFF_RELOAD_A);
		wr_crb   = wr_i && (addr_i == mft_pkg::OFF_RELOAD_B);
		wr_ien   = wr_i && (addr_i == mft_pkg::OFF_IRQ_ENABLE);
		wr_pend  = wr_i && (addr_i == mft_pkg::OFF_IRQ_PENDING);
		wr_route = wr_i && (addr_i == mft_pkg::OFF_ROUTING);
	end

	// Pin sources: routed IO only in the capture modes
	always_comb begin
		mode = timer_mode_control.mode_select_field;
		if (TIMER_UNIT) begin
			route_a_code = timer_input_routing[mft_pkg::ROUTE_T2A_LSB +: mft_pkg::ROUTE_W];
			route_b_code = timer_input_routing[mft_pkg::ROUTE_T2B_LSB +: mft_pkg::ROUTE_W];
		end else begin
			route_a_code = timer_input_routing[mft_pkg::ROUTE_T1A_LSB +: mft_pkg::ROUTE_W];
			route_b_code = timer_input_routing[mft_pkg::ROUTE_T1B_LSB +: mft_pkg::ROUTE_W];
		end
		routed    = (mode == mft_pkg::MODE_DUAL_CAPTURE) || (mode == mft_pkg::MODE_SINGLE_CAPTURE);
		pin_a_src = routed ? route_pick(route_a_code, io_i) : pin_a_i;
		pin_b_src = routed ? route_pick(route_b_code, io_i) : pin_b_i;
	end

	edge_detect u_edge_a (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.pin_i    (pin_a_src),
		.rising_i (timer_mode_control.pin_a_rising),
		.edge_o   (edge_a)
	);

	edge_detect u_edge_b (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.pin_i    (pin_b_src),
		.rising_i (timer_mode_control.pin_b_rising),
		.edge_o   (edge_b)
	);

	prescaler u_prescaler (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.run_i   (timer_mode_control.enable),
		.div_i   (prescale_div),
		.tick_o  (pre_tick)
	);

	// Counting pulses and underflow detection
	always_comb begin
		is_train = (mode == mft_pkg::MODE_PWM) && timer_mode_control.pulse_train;
		run_one  = timer_mode_control.enable && (counter_clock_select.one != mft_pkg::CLK_NONE)
			&& !(is_train && train_stopped);
		tick_one = run_one && source_tick(counter_clock_select.one, pre_tick, edge_b, pin_b_src);
		// Pin B is a capture input here, so every source but the prescaled one stops counter one
		if ((mode == mft_pkg::MODE_DUAL_CAPTURE) && (counter_clock_select.one != mft_pkg::CLK_PRESCALED)) begin
			tick_one = 1'b0;
		end
		under_one = tick_one && (counter_one == mft_pkg::CNT_ZERO);
		if (is_train) begin
			tick_two = under_one;
		end else begin
			tick_two = timer_mode_control.enable
				&& source_tick(counter_clock_select.two, pre_tick, edge_b, pin_b_src);
		end
		under_two = tick_two && (counter_two == mft_pkg::CNT_ZERO);
	end

	// Counters, reload/capture registers, PWM pin and pending flags
	always_comb begin
		next_counter_one      = counter_one;
		next_counter_two      = counter_two;
		next_reload_capture_a = reload_capture_a;
		next_reload_capture_b = reload_capture_b;
		next_reload_order     = reload_order;
		next_train_stopped    = train_stopped;
		next_pin              = pwm_output_pin_o;
		set_pend              = 4'h0;

		// Counter one
		if (tick_one) begin
			next_counter_one = counter_one - 16'h0001;
		end
		if (under_one) begin
			case (mode)
				mft_pkg::MODE_PWM: begin
					if (reload_order == mft_pkg::NEXT_RELOAD_A) begin
						next_counter_one  = reload_capture_a;
						next_reload_order = mft_pkg::NEXT_RELOAD_B;
						set_pend[mft_pkg::IRQ_A] = 1'b1;
					end else begin
						next_counter_one  = reload_capture_b;
						next_reload_order = mft_pkg::NEXT_RELOAD_A;
						set_pend[mft_pkg::IRQ_B] = 1'b1;
					end
					next_pin = ~pwm_output_pin_o;
				end
				mft_pkg::MODE_DUAL_TIMER: begin
					next_counter_one = reload_capture_a;
					next_pin = ~pwm_output_pin_o;
					set_pend[mft_pkg::IRQ_C] = 1'b1;
				end
				mft_pkg::MODE_SINGLE_CAPTURE: begin
					next_counter_one = reload_capture_a;
					set_pend[mft_pkg::IRQ_C] = 1'b1;
				end
				default: begin
					next_counter_one = mft_pkg::CNT_PRESET;
					set_pend[mft_pkg::IRQ_C] = 1'b1;
				end
			endcase
		end

		// Any stop or mode change rearms the first reload from A
		if (!run_one || (mode != mft_pkg::MODE_PWM)) begin
			next_reload_order = mft_pkg::NEXT_RELOAD_A;
		end
		// Idle pin follows the level being written, so a start in that same write begins there
		if (!run_one) begin
			next_pin = next_mode_control.initial_output_level;
		end

		// Captures
		if (timer_mode_control.enable && (mode == mft_pkg::MODE_DUAL_CAPTURE) && edge_a) begin
			next_reload_capture_a = counter_one;
			set_pend[mft_pkg::IRQ_A] = 1'b1;
			if (timer_mode_control.pin_a_preset) begin
				next_counter_one = mft_pkg::CNT_PRESET;
			end
		end
		if (timer_mode_control.enable && routed && edge_b) begin
			next_reload_capture_b = counter_one;
			set_pend[mft_pkg::IRQ_B] = 1'b1;
			if (timer_mode_control.pin_b_preset) begin
				next_counter_one = mft_pkg::CNT_PRESET;
			end
		end

		// Counter two
		if (tick_two) begin
			next_counter_two = counter_two - 16'h0001;
		end
		if (under_two) begin
			set_pend[mft_pkg::IRQ_D] = 1'b1;
			if (is_train) begin
				// Pulse count exhausted: hold at zero and freeze counter one
				next_counter_two   = mft_pkg::CNT_ZERO;
				next_train_stopped = 1'b1;
			end else if (mode == mft_pkg::MODE_DUAL_TIMER) begin
				next_counter_two = reload_capture_b;
			end else begin
				next_counter_two = mft_pkg::CNT_PRESET;
			end
		end
		if (!is_train) begin
			next_train_stopped = 1'b0;
		end

		// Software writes take precedence over counting
		if (wr_cnt1) begin
			next_counter_one = wdata_i[15:0];
		end
		if (wr_cnt2) begin
			next_counter_two   = wdata_i[15:0];
			next_train_stopped = 1'b0;
		end
		if (wr_cra) begin
			next_reload_capture_a = wdata_i[15:0];
		end
		if (wr_crb) begin
			next_reload_capture_b = wdata_i[15:0];
		end

		// Hardware set wins over a software clear in the same cycle
		next_irq_pending = irq_pending;
		if (wr_pend) begin
			next_irq_pending = irq_pending & ~wdata_i[3:0];
		end
		next_irq_pending = next_irq_pending | set_pend;

		// One line per counter, each gated by its own enables
		next_irq_one = |(next_irq_pending[2:0] & irq_enable[2:0]);
		next_irq_two = next_irq_pending[mft_pkg::IRQ_D] & irq_enable[mft_pkg::IRQ_D];
		next_oe = timer_mode_control.enable
			&& ((mode == mft_pkg::MODE_PWM) || (mode == mft_pkg::MODE_DUAL_TIMER));
	end

	// Configuration registers; reserved bits are stored as zero
	always_comb begin
		next_mode_control = timer_mode_control;
		next_clock_select = counter_clock_select;
		next_prescale_div = prescale_div;
		next_irq_enable   = irq_enable;
		next_routing      = timer_input_routing;
		if (wr_ctrl) begin
			next_mode_control          = mft_pkg::mode_control_s'(wdata_i);
			next_mode_control.reserved = '0;
		end
		if (wr_clk) begin
			next_clock_select          = mft_pkg::clock_select_s'(wdata_i);
			next_clock_select.reserved = '0;
			next_clock_select.gap      = 1'b0;
		end
		if (wr_pre) begin
			next_prescale_div = wdata_i[7:0];
		end
		if (wr_ien) begin
			next_irq_enable = wdata_i[3:0];
		end
		if (wr_route) begin
			next_routing = wdata_i;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_comb begin
		next_rdata = 32'h00000000;
		if (rd_i) begin
			if (addr_i == mft_pkg::OFF_MODE_CONTROL) begin
				next_rdata = timer_mode_control;
			end else if (addr_i == mft_pkg::OFF_CLOCK_SELECT) begin
				next_rdata = counter_clock_select;
			end else if (addr_i == mft_pkg::OFF_PRESCALER) begin
				next_rdata = {24'h000000, prescale_div};
			end else if (addr_i == mft_pkg::OFF_COUNTER_ONE) begin
				next_rdata = {16'h0000, counter_one};
			end else if (addr_i == mft_pkg::OFF_COUNTER_TWO) begin
				next_rdata = {16'h0000, counter_two};
			end else if (addr_i == mft_pkg::OFF_RELOAD_A) begin
				next_rdata = {16'h0000, reload_capture_a};
			end else if (addr_i == mft_pkg::OFF_RELOAD_B) begin
				next_rdata = {16'h0000, reload_capture_b};
			end else if (addr_i == mft_pkg::OFF_IRQ_ENABLE) begin
				next_rdata = {28'h0000000, irq_enable};
			end else if (addr_i == mft_pkg::OFF_IRQ_PENDING) begin
				next_rdata = {28'h0000000, irq_pending};
			end else if (addr_i == mft_pkg::OFF_ROUTING) begin
				next_rdata = timer_input_routing;
			end
		end
	end

	// State registers
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			timer_mode_control   <= mft_pkg::mode_control_s'(mft_pkg::MODE_CONTROL_RST);
			counter_clock_select <= mft_pkg::clock_select_s'(mft_pkg::CLOCK_SELECT_RST);
			prescale_div         <= mft_pkg::PRESCALER_RST;
			counter_one          <= mft_pkg::COUNTER_RST;
			counter_two          <= mft_pkg::COUNTER_RST;
			reload_capture_a     <= mft_pkg::RELOAD_RST;
			reload_capture_b     <= mft_pkg::RELOAD_RST;
			irq_enable           <= mft_pkg::IRQ_RST;
			irq_pending          <= mft_pkg::IRQ_RST;
			timer_input_routing  <= mft_pkg::ROUTING_RST;
			reload_order         <= mft_pkg::NEXT_RELOAD_A;
			train_stopped        <= 1'b0;
			pwm_output_pin_o     <= 1'b0;
			pin_a_oe_o           <= 1'b0;
			irq_one_o            <= 1'b0;
			irq_two_o            <= 1'b0;
			rdata_o              <= 32'h00000000;
		end else begin
			timer_mode_control   <= next_mode_control;
			counter_clock_select <= next_clock_select;
			prescale_div         <= next_prescale_div;
			counter_one          <= next_counter_one;
			counter_two          <= next_counter_two;
			reload_capture_a     <= next_reload_capture_a;
			reload_capture_b     <= next_reload_capture_b;
			irq_enable           <= next_irq_enable;
			irq_pending          <= next_irq_pending;
			timer_input_routing  <= next_routing;
			reload_order         <= next_reload_order;
			train_stopped        <= next_train_stopped;
			pwm_output_pin_o     <= next_pin;
			pin_a_oe_o           <= next_oe;
			irq_one_o            <= next_irq_one;
			irq_two_o            <= next_irq_two;
			rdata_o              <= next_rdata;
		end
	end
endmodule

//--- test/multifunction_timer_assertions.sv
// Checker for the timer: register port and interrupt timing.
// Assumes it is bound to the top module and sees only its ports.
module multifunction_timer_assertions (
	// Clock and reset
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	// Register port
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Pins and interrupts
	input wire logic        pwm_output_pin_o,
	input wire logic        pin_a_oe_o,
	input wire logic        irq_one_o,
	input wire logic        irq_two_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	// Quiet outputs at release
	property p_rst_quiet;
		$rose(rst_n_i) |-> !pwm_output_pin_o && !pin_a_oe_o && !irq_one_o && !irq_two_o;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
	// Read data only stands after a read
	property p_rdata_idle;
		!$past(rd_i) |-> rdata_o == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
	property p_unmapped;
		rd_i && addr_i == 8'h30 |=> rdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	// Write then read back, masked to the field width
	property p_route_back;
		wr_i && addr_i == 8'h44 ##1 rd_i && addr_i == 8'h44 |=> rdata_o == $past(wdata_i, 2);
	endproperty
	a_route_back: assert property (p_route_back) else $error("routing readback");
	property p_reload_back;
		wr_i && addr_i == 8'h14 ##1 rd_i && addr_i == 8'h14 |=> rdata_o == ($past(wdata_i, 2) & 32'h0000FFFF);
	endproperty
	a_reload_back: assert property (p_reload_back) else $error("reload A readback");
	property p_presc_back;
		wr_i && addr_i == 8'h08 ##1 rd_i && addr_i == 8'h08 |=> rdata_o == ($past(wdata_i, 2) & 32'h000000FF);
	endproperty
	a_presc_back: assert property (p_presc_back) else $error("prescaler readback");
	property p_clksel_back;
		wr_i && addr_i == 8'h04 ##1 rd_i && addr_i == 8'h04 |=> rdata_o == ($past(wdata_i, 2) & 32'h00000077);
	endproperty
	a_clksel_back: assert property (p_clksel_back) else $error("clock select readback");
	// Masking takes effect on the interrupt two cycles on
	property p_irq_one_off;
		wr_i && addr_i == 8'h1C && wdata_i[2:0] == 3'h0 |-> ##2 !irq_one_o;
	endproperty
	a_irq_one_off: assert property (p_irq_one_off) else $error("masked irq one high");
	property p_irq_two_off;
		wr_i && addr_i == 8'h1C && !wdata_i[3] |-> ##2 !irq_two_o;
	endproperty
	a_irq_two_off: assert property (p_irq_two_off) else $error("masked irq two high");
endmodule

bind multifunction_timer multifunction_timer_assertions u_chk (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .pwm_output_pin_o(pwm_output_pin_o), .pin_a_oe_o(pin_a_oe_o),
	.irq_one_o(irq_one_o), .irq_two_o(irq_two_o)
);

//--- test/pin_source.sv
// External sources on the timer pins and routed IO.
// Assumes pulse() is called from the bench's procedural flow.
module pin_source (
	// Clock
	input  wire logic        mclk_i,
	// Timer pins and routed IO
	output logic             pin_a_o,
	output logic             pin_b_o,
	output logic      [25:0] io_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		pin_a_o = 1'b0;
		pin_b_o = 1'b0;
		io_o = 26'h0;
	end
	// Held two clocks: wider than the one-clock minimum; index 26 is pin B
	task automatic pulse(input int idx);
		@(posedge mclk_i);
		if (idx == 26) begin
			pin_b_o <= 1'b1;
		end else begin
			io_o[idx] <= 1'b1;
		end
		repeat (2) @(posedge mclk_i);
		pin_b_o <= 1'b0;
		io_o <= 26'h0;
		repeat (2) @(posedge mclk_i);
	endtask
endmodule

//--- test/tb_multifunction_timer.sv
// Testbench for the timer: registers, PWM, restart, capture, counter two.
// Assumes the bound checker and the pin_source partner model.
module tb_multifunction_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [31:0] rdata_o, rv, a;
	logic        pin_a_i, pin_b_i, pwm_output_pin_o, pin_a_oe_o, irq_one_o, irq_two_o;
	logic [25:0] io_i;
	int          err_total = 0;
	int          checks = 0;
	always #4 mclk_i = ~mclk_i;
	multifunction_timer u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_a_i(pin_a_i), .pin_b_i(pin_b_i), .io_i(io_i),
		.pwm_output_pin_o(pwm_output_pin_o), .pin_a_oe_o(pin_a_oe_o), .irq_one_o(irq_one_o),
		.irq_two_o(irq_two_o));
	pin_source u_src (.mclk_i(mclk_i), .pin_a_o(pin_a_i), .pin_b_o(pin_b_i), .io_o(io_i));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= ad;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// Read data is taken in the single cycle after the strobe
	task automatic rd(input logic [7:0] ad);
		@(posedge mclk_i);
		addr_i <= ad;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask
	task automatic wrrd(input logic [7:0] ad, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= ad;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask
	// Cycles until the PWM pin next changes, bounded
	task automatic phase(output int n);
		logic p;
		p = pwm_output_pin_o;
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
		end while (pwm_output_pin_o === p && n < 100);
	endtask
	task automatic t_regs;
		rd(8'h44);
		chk(rv, 32'h0);
		wrrd(8'h44, 32'h19190705);
		chk(rv, 32'h19190705);
		wrrd(8'h14, 32'h0000ABCD);
		chk(rv, 32'h0000ABCD);
		wrrd(8'h08, 32'h000000A5);
		chk(rv, 32'h000000A5);
		wrrd(8'h04, 32'h00000077);
		chk(rv, 32'h00000077);
		wrrd(8'h0C, 32'h0000BEEF);
		chk(rv, 32'h0000BEEF);
		rd(8'h30);
		chk(rv, 32'h0);
		$display("register test done");
	endtask
	task automatic pwm_run(input logic [1:0] md, input logic lvl, input int e1, input int e2);
		int n;
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h0);
		wr(8'h0C, 32'h1);
		wr(8'h14, 32'h3);
		wr(8'h18, 32'h5);
		wr(8'h20, 32'hF);
		wr(8'h1C, 32'h3);
		wr(8'h00, {28'h0, lvl, 1'b1, md});
		// Step off the enabling edge so the start level is settled before it is noted
		@(negedge mclk_i);
		phase(n);
		chk(pwm_output_pin_o, !lvl);
		phase(n);
		chk(n, e1);
		phase(n);
		chk(n, e2);
		chk(pin_a_oe_o, 1'b1);
		if (md == 2'h0) begin
			rd(8'h20);
			chk(rv & 32'h3, 32'h3);
			chk(irq_one_o, 1'b1);
		end
		$display("pwm test done");
	endtask
	// Stop issued after an A reload lands on the same edge as the B reload, so A is next; the restart must reload from A first
	task automatic t_restart;
		int n;
		n = 0;
		while (pwm_output_pin_o !== 1'b1 && n < 100) begin
			@(negedge mclk_i);
			n++;
		end
		chk(pwm_output_pin_o, 32'h1);
		wr(8'h04, 32'h0);
		wr(8'h20, 32'hF);
		wr(8'h0C, 32'h1);
		wr(8'h04, 32'h1);
		n = 0;
		while (pwm_output_pin_o !== 1'b1 && n < 100) begin
			@(negedge mclk_i);
			n++;
		end
		chk(pwm_output_pin_o, 32'h1);
		rd(8'h20);
		chk(rv & 32'h3, 32'h1);
		wr(8'h04, 32'h0);
		wr(8'h20, 32'hF);
		repeat (2) @(negedge mclk_i);
		chk(irq_one_o, 1'b0);
		$display("restart test done");
	endtask
	task automatic t_capture;
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		wr(8'h0C, 32'h100);
		wr(8'h20, 32'hF);
		wr(8'h00, 32'h65);
		// Let counter one move off its preload before the first capture
		repeat (4) @(posedge mclk_i);
		u_src.pulse(5);
		rd(8'h14);
		a = rv;
		chk(a > 32'h0 && a < 32'h100, 32'h1);
		u_src.pulse(7);
		rd(8'h18);
		chk(rv > 32'h0 && rv < a, 32'h1);
		rd(8'h20);
		chk(rv & 32'h3, 32'h3);
		wr(8'h20, 32'hF);
		wr(8'h00, 32'h47);
		u_src.pulse(7);
		rd(8'h20);
		chk(rv & 32'h2, 32'h2);
		$display("capture test done");
	endtask
	task automatic t_count_two;
		wr(8'h00, 32'h0);
		wr(8'h1C, 32'h0);
		wr(8'h04, 32'h20);
		wr(8'h10, 32'h1);
		wr(8'h20, 32'hF);
		wr(8'h00, 32'h44);
		u_src.pulse(26);
		rd(8'h20);
		chk(rv & 32'h8, 32'h0);
		u_src.pulse(26);
		rd(8'h20);
		chk(rv & 32'h8, 32'h8);
		chk(irq_two_o, 1'b0);
		wr(8'h1C, 32'h8);
		repeat (2) @(negedge mclk_i);
		chk(irq_two_o, 1'b1);
		$display("counter two test done");
	endtask
	// Pulse train: counter two counts counter one underflows, then freezes it
	task automatic t_train;
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		wr(8'h0C, 32'h1);
		wr(8'h14, 32'h2);
		wr(8'h18, 32'h2);
		wr(8'h10, 32'h1);
		wr(8'h20, 32'hF);
		wr(8'h00, 32'h14);
		repeat (20) @(negedge mclk_i);
		rd(8'h10);
		chk(rv, 32'h0);
		rd(8'h20);
		chk(rv & 32'h8, 32'h8);
		rd(8'h0C);
		chk(rv, 32'h2);
		rd(8'h0C);
		chk(rv, 32'h2);
		$display("pulse train test done");
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// The whole sequence needs well under a thousand cycles
	initial begin
		#50000;
		err_total++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_regs;
		pwm_run(2'h0, 1'b0, 4, 6);
		t_restart;
		pwm_run(2'h0, 1'b1, 4, 6);
		pwm_run(2'h2, 1'b0, 4, 4);
		t_capture;
		t_count_two;
		t_train;
		tally_and_finish;
	end
endmodule
